// [rtl/ros_pkg.sv]
`default_nettype none
package ros_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses, one aligned word per register)
  // ----------------------------------------------------------------
  localparam int          NUM_REGS      = 8;
  localparam int          NUM_PINS      = 16;
  localparam int          SEL_W         = 5;
  localparam int          REG_W         = 16;
  localparam int          ADDR_W        = 12;
  localparam logic [11:0] OUT_SEL_BASE  = 12'h000;
  localparam logic [11:0] OUT_SEL_LAST  = 12'h01C;

  // ----------------------------------------------------------------
  // field layout
  // ----------------------------------------------------------------
  localparam int          EVEN_SEL_LSB  = 0;
  localparam int          ODD_SEL_LSB   = 8;
  localparam logic [15:0] IMPL_MASK     = 16'h1F1F;
  localparam logic [15:0] OUT_SEL_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // selector codes
  // ----------------------------------------------------------------
  localparam logic [4:0]  SEL_NONE      = 5'h00;
  localparam int          NUM_FUNCS     = 32;

endpackage : ros_pkg
`default_nettype wire

// [rtl/ros_out_select.sv]
`default_nettype none

// How it works
// - each register holds odd pin selector bits 12-8, even pin bits 4-0.
// - bits 15-13 and 7-5 ignore writes and read zero.
// - power-on reset clears every selector to zero.
// - selector bits are read/write and read back the last value written.
// - register n serves pins 2n and 2n+1; eight registers cover sixteen pins.
module ros_out_select #(
  parameter int NUM_FUNCS = ros_pkg::NUM_FUNCS
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [11:0]           paddr,
  input  wire logic [31:0]           pwdata,
  input  wire logic [3:0]            pstrb,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic [NUM_FUNCS-1:0]  periph_out,
  input  wire logic [15:0]           port_latch_out,
  output logic      [15:0]           remappable_pin,
  output logic      [15:0]           pin_routed
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ros_pkg::NUM_REGS-1:0][15:0] sel;
    logic [31:0]                        rdata;
    logic [15:0]                        pin;
    logic [15:0]                        routed;
  } ros_state_t;

  ros_state_t state_reg;
  ros_state_t state_next;

  function automatic logic addr_hit(input logic [11:0] a);
    addr_hit = (a[1:0] == 2'h0) && (a >= ros_pkg::OUT_SEL_BASE)
               && (a <= ros_pkg::OUT_SEL_LAST);
  endfunction : addr_hit

  function automatic logic [2:0] addr_idx(input logic [11:0] a);
    logic [11:0] off;
    off = a - ros_pkg::OUT_SEL_BASE;
    addr_idx = off[4:2];
  endfunction : addr_idx

  // pick one selector field for a pin
  function automatic logic [4:0] pin_sel(
    input logic [ros_pkg::NUM_REGS-1:0][15:0] s,
    input int p
  );
    logic [15:0] r;
    r = s[p / 2];
    if (p % 2 == 1) begin
      pin_sel = r[ros_pkg::ODD_SEL_LSB +: ros_pkg::SEL_W];
    end else begin
      pin_sel = r[ros_pkg::EVEN_SEL_LSB +: ros_pkg::SEL_W];
    end
  endfunction : pin_sel

  logic access;
  logic hit;

  assign access  = psel && penable;
  assign hit     = addr_hit(paddr);
  assign pready  = 1'b1;
  assign prdata  = state_reg.rdata;
  assign pslverr = access && !hit;
  assign remappable_pin = state_reg.pin;
  assign pin_routed     = state_reg.routed;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] wmask;
    logic [15:0] cur;
    logic [4:0]  code;
    logic [2:0]  idx;
    wmask = 16'h0000;
    cur   = 16'h0000;
    code  = 5'h00;
    idx   = addr_idx(paddr);
    state_next = state_reg;
    if (access && pwrite && hit) begin
      wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
      cur = state_reg.sel[idx];
      state_next.sel[idx] = ((cur & ~wmask) | (pwdata[15:0] & wmask))
                            & ros_pkg::IMPL_MASK;
    end
    if (psel && !penable && !pwrite) begin
      if (hit) begin
        state_next.rdata = {16'h0000,
                            state_reg.sel[idx] & ros_pkg::IMPL_MASK};
      end else begin
        state_next.rdata = 32'h0000_0000;
      end
    end
    for (int p = 0; p < ros_pkg::NUM_PINS; p++) begin
      code = pin_sel(state_reg.sel, p);
      if (code == ros_pkg::SEL_NONE || int'(code) >= NUM_FUNCS) begin
        state_next.pin[p]    = port_latch_out[p];
        state_next.routed[p] = 1'b0;
      end else begin
        state_next.pin[p]    = periph_out[code];
        state_next.routed[p] = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < ros_pkg::NUM_REGS; i++) begin
        state_reg.sel[i] <= ros_pkg::OUT_SEL_RESET;
      end
      state_reg.rdata  <= 32'h0000_0000;
      state_reg.pin    <= 16'h0000;
      state_reg.routed <= 16'h0000;
    end else begin
      state_reg <= state_next;
    end
  end

endmodule : ros_out_select
`default_nettype wire

// [tb/ros_out_select_sva.sv]
`default_nettype none
module ros_out_select_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [15:0] port_latch_out,
  input wire logic [15:0] remappable_pin,
  input wire logic [15:0] pin_routed
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  AST_FIELD_MAP: assert property (
    acc && pwrite && paddr == 12'h000 && pstrb[1:0] == 2'h3 |-> ##2
    pin_routed[1:0] == {|$past(pwdata[12:8], 2), |$past(pwdata[4:0], 2)})
    else $error("selector field lands on wrong pin");
  AST_RSV_ZERO: assert property (
    acc && !pwrite |-> (prdata & ~32'h1F1F) == 32'h0)
    else $error("unused bits read nonzero");
  AST_RST_CLEAR: assert property (
    $rose(presetn) |-> pin_routed == 16'h0 && prdata == 32'h0)
    else $error("route active after reset");
  AST_ZERO_WAIT: assert property (
    acc |-> pready) else $error("access not answered");
  AST_MAP_RANGE: assert property (
    acc && paddr > 12'h01C |-> pslverr && (pwrite || prdata == 32'h0))
    else $error("unmapped access accepted");
  AST_PORT_PASS: assert property (
    $past(presetn) |-> (remappable_pin & ~pin_routed) ==
    ($past(port_latch_out) & ~pin_routed)) else $error("port value lost");
  cover property (acc && pwrite);
  cover property (acc && !pwrite && prdata != 32'h0);
  cover property (acc && pslverr);
endmodule : ros_out_select_sva
bind ros_out_select ros_out_select_sva u_sva (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
  .port_latch_out, .remappable_pin, .pin_routed);
`default_nettype wire

// [tb/ros_periph_model.sv]
`default_nettype none
module ros_periph_model (
  input  wire logic        pclk,
  output logic      [31:0] periph_out,
  output logic      [15:0] port_latch_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {periph_out, port_latch_out} = 48'h0;
  // fresh values each cycle so a stale route is unlikely to pass for many cycles
  always @(posedge pclk) begin
    periph_out     <= $urandom;
    port_latch_out <= 16'($urandom);
  end
endmodule : ros_periph_model
`default_nettype wire

// [tb/ros_out_select_tb.sv]
`default_nettype none
module ros_out_select_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, ok;
  logic [11:0] paddr;
  logic [3:0]  pstrb;
  logic [15:0] wm;
  logic [31:0] pwdata, prdata, periph_out, nx, exp_q[$];
  logic [15:0] port_latch_out, remappable_pin, pin_routed, sel_copy[8];
  int          num_errors, checks_done;
  ros_out_select uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .periph_out,
    .port_latch_out, .remappable_pin, .pin_routed);
  ros_periph_model peer (.pclk, .periph_out, .port_latch_out);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic stop_test;
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : stop_test
  function automatic logic [31:0] route_of;
    logic [15:0] p, r;
    logic [4:0]  s;
    for (int i = 0; i < 16; i++) begin
      s = sel_copy[i/2][i%2*8+:5];
      r[i] = s != 5'h00;
      p[i] = r[i] ? periph_out[s] : port_latch_out[i];
    end
    return {r, p};
  endfunction : route_of
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    if (!w) exp_q.push_back(a > 12'h01C ? 32'h0 : {16'h0, sel_copy[a[4:2]]});
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    pstrb  <= 4'($urandom);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : bus
  always @(posedge pclk) begin
    if (!presetn) begin
      ok = 0;
      sel_copy = '{default: 16'h0};
    end else begin
      if (ok) chk({pin_routed, remappable_pin}, nx);
      nx = route_of();
      ok = 1;
      if (psel && penable && !pwrite) chk(prdata, exp_q.pop_front());
      if (psel && penable && pwrite && paddr <= 12'h01C) begin
        wm = {{8{pstrb[1]}}, {8{pstrb[0]}}};
        sel_copy[paddr[4:2]] = ((sel_copy[paddr[4:2]] & ~wm)
                               | (pwdata[15:0] & wm)) & 16'h1F1F;
      end
    end
  end
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #2000 num_errors++;
    stop_test();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    void'($urandom(32'h4DBB));
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int j = 0; j < 5; j++)
      for (int i = 0; i < 9; i++)
        bus(j[0], 12'(i * 4), j == 3 ? $urandom & 32'hFF00 : $urandom);
    stop_test();
  end
endmodule : ros_out_select_tb
`default_nettype wire
